// *** design/hbwl_adapter.v ***
// host bus width and byte lane adapter between an sram-like host port and a 32-bit core port
// assumes host strobes are already synchronous to clk; the width strap is asynchronous
// the strap is latched once, a few edges after reset, and held until the next reset
// Summary of operation
// - strap pin selects 32 or 16 bit
// - strapped width readable at config bit 2
// - 32-bit mode: one access, one dword
// - write halves accepted in either order
// - read halves accepted in either order
// - repeated same-half write is discarded
// - repeated same-half read is flagged invalid and ends read pairing
// - 16-bit mode leaves upper lines undriven
// - 32-bit mode bytes 3..0 top to bottom
// - swap value: a1 low gives bytes 3,2
// - other value: a1 low gives bytes 1,0
`timescale 1ns/1ps
`include "hbwl_defines.vh"
module hbwl_adapter #(
  parameter AW = 8
) (
  input wire clk,
  input wire srst,
  input wire width_strap_pin,
  input wire [31:0] byte_order,
  input wire host_wr,
  input wire host_rd,
  input wire [AW-1:0] host_addr,
  input wire [31:0] host_din,
  output reg [31:0] host_dout,
  output reg [31:0] host_doe_n,
  output reg host_rd_invalid,
  output reg core_wr,
  output reg core_rd,
  output reg [AW-1:0] core_addr,
  output reg [31:0] core_wdata,
  input wire [31:0] core_rdata,
  output wire [`HBWL_CFG_W-1:0] hardware_config_reg,
  output wire bus_width_select
);
  // filtered strap level and latched width
  wire strap_sync;
  reg width32_q;
  // edges since reset, for the strap settle wait
  reg [2:0] settle_q;
  // write pairing state
  reg wr_pend_q;
  reg wr_half_q;
  reg [15:0] wr_hold_q;
  reg [AW-1:0] wr_addr_q;
  // read pairing state
  reg rd_pend_q;
  reg rd_half_q;
  reg [15:0] rd_hold_q;
  reg rd_wait_q;
  reg rd_wait_half_q;
  // half of the dword selected by address bit 1
  reg sel_hi;
  wire swap;

  // pick one half of a dword; used for the driven and the saved half
  function [15:0] pick_half;
    input [31:0] word;
    input hi;
    begin
      pick_half = hi ? word[31:16] : word[15:0];
    end
  endfunction

  // strap passes four flops (three stages and the filtered output) before use
  hbwl_sync3 u_sync (
    .clk(clk),
    .srst(srst),
    .din(width_strap_pin),
    .dout(strap_sync)
  );

  // width strap capture
  // the synchroniser is cleared by reset, so wait until it shows the pin
  always @(posedge clk) begin
    if (srst) begin
      width32_q <= 1'b1;
      settle_q <= 3'h0;
    end else begin
      // count to the settle point, then hold
      if (settle_q != `HBWL_STRAP_SETTLE) begin
        settle_q <= settle_q + 3'h1;
      end
      // latch the filtered strap exactly once
      if (settle_q == (`HBWL_STRAP_SETTLE - 3'h1)) begin
        width32_q <= strap_sync;
      end
    end
  end

  // width readback bit
  // all other readback bits read as zero
  assign hardware_config_reg = {{(`HBWL_CFG_W-1-`HBWL_CFG_WIDTH_BIT){1'b0}}, width32_q,
    {`HBWL_CFG_WIDTH_BIT{1'b0}}};
  assign bus_width_select = width32_q;

  // swap value detection
  // byte order must stay put across a half-word pair
  assign swap = (byte_order == `HBWL_ORDER_SWAP);

  // map address bit 1 to the dword half it carries
  always @* begin
    // non-swap maps a1 low to low half
    sel_hi = host_addr[1] ^ swap;
  end

  // core-side write assembly and read request
  always @(posedge clk) begin
    if (srst) begin
      core_wr <= 1'b0;
      core_rd <= 1'b0;
      core_addr <= {AW{1'b0}};
      core_wdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_half_q <= `HBWL_HALF_LO;
      wr_hold_q <= 16'h0000;
      wr_addr_q <= {AW{1'b0}};
      rd_pend_q <= 1'b0;
      rd_half_q <= `HBWL_HALF_LO;
      rd_wait_q <= 1'b0;
      rd_wait_half_q <= 1'b0;
    end else begin
      // strobes default low each cycle
      core_wr <= 1'b0;
      core_rd <= 1'b0;
      rd_wait_q <= 1'b0;
      if (width32_q) begin
        // direct dword access
        // a write wins when both strobes stand
        if (host_wr) begin
          core_wr <= 1'b1;
          core_addr <= {host_addr[AW-1:2], 2'b00};
          core_wdata <= host_din;
        end else if (host_rd) begin
          core_rd <= 1'b1;
          core_addr <= {host_addr[AW-1:2], 2'b00};
          rd_wait_q <= 1'b1;
        end
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
      end else begin
        if (host_wr) begin
          if (!wr_pend_q) begin
            // first half held
            wr_pend_q <= 1'b1;
            wr_half_q <= sel_hi;
            wr_hold_q <= host_din[15:0];
            wr_addr_q <= {host_addr[AW-1:2], 2'b00};
          end else if (sel_hi == wr_half_q) begin
            wr_pend_q <= wr_pend_q;
          end else begin
            wr_pend_q <= 1'b0;
            core_wr <= 1'b1;
            core_addr <= wr_addr_q;
            core_wdata <= sel_hi ? {host_din[15:0], wr_hold_q} : {wr_hold_q, host_din[15:0]};
          end
        end else if (host_rd) begin
          // data goes out one edge later
          rd_wait_q <= 1'b1;
          rd_wait_half_q <= sel_hi;
          if (!rd_pend_q) begin
            // first read fetches the whole dword
            rd_pend_q <= 1'b1;
            rd_half_q <= sel_hi;
            core_rd <= 1'b1;
            core_addr <= {host_addr[AW-1:2], 2'b00};
          end else begin
            rd_pend_q <= 1'b0;
          end
        end
      end
    end
  end

  // host read data, held other half and drive enables
  always @(posedge clk) begin
    if (srst) begin
      host_dout <= 32'h00000000;
      host_doe_n <= 32'hFFFFFFFF;
      host_rd_invalid <= 1'b0;
      rd_hold_q <= 16'h0000;
    end else begin
      // invalid flag is a one-cycle pulse
      host_rd_invalid <= 1'b0;
      if (rd_wait_q) begin
        if (width32_q) begin
          host_dout <= core_rdata;
          host_doe_n <= 32'h00000000;
        end else begin
          host_doe_n <= 32'hFFFF0000;
          if (rd_pend_q) begin
            // first half from fresh dword, other half saved
            host_dout <= {16'h0000, pick_half(core_rdata, rd_wait_half_q)};
            rd_hold_q <= pick_half(core_rdata, !rd_wait_half_q);
          end else begin
            // second half from saved copy; same half flagged invalid
            host_dout <= {16'h0000, rd_hold_q};
            host_rd_invalid <= (rd_wait_half_q == rd_half_q);
          end
        end
      end else begin
        // lanes released when no read data is due
        host_doe_n <= 32'hFFFFFFFF;
      end
    end
  end
endmodule // hbwl_adapter

// *** design/hbwl_defines.vh ***
// constants for the host bus width and lane adapter
// assumes inclusion by bare name from design files
`ifndef HBWL_DEFINES_VH
`define HBWL_DEFINES_VH
// hardware configuration readback bit holding the strapped width
`define HBWL_CFG_WIDTH_BIT 2
// width of the readback word
`define HBWL_CFG_W 32
// byte order value that selects the swapped half mapping
`define HBWL_ORDER_SWAP 32'hFFFFFFFF
// reset value of the byte order register
`define HBWL_ORDER_RST 32'h00000000
// edges after reset before the filtered strap is trusted
`define HBWL_STRAP_SETTLE 3'h5
// half pairing encodings: which half is held
`define HBWL_HALF_LO 1'b0
`define HBWL_HALF_HI 1'b1
`endif

// *** design/hbwl_sync3.v ***
// three-stage input synchroniser with agreement filter
// assumes an asynchronous level on din; dout follows once stages two and three agree
`timescale 1ns/1ps
module hbwl_sync3 (
  input wire clk,
  input wire srst,
  input wire din,
  output reg dout
);
  // synchroniser stages
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // shift chain and filtered output
  always @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change accepted only when later stages agree
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // hbwl_sync3

// *** sim/hbwl_props.sv ***
// port checker for the lane adapter
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module hbwl_props #(
  parameter AW = 8
) (
  input wire clk,
  input wire srst,
  input wire host_wr,
  input wire host_rd,
  input wire [31:0] host_dout,
  input wire [31:0] host_doe_n,
  input wire host_rd_invalid,
  input wire core_wr,
  input wire core_rd,
  input wire [AW-1:0] core_addr,
  input wire [31:0] hardware_config_reg,
  input wire bus_width_select
);
  // cycles since reset release, saturating; the strap is latched early on
  reg [3:0] up_q = 4'h0;
  always @(posedge clk) begin
    if (srst) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hF) begin
      up_q <= up_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_cfg_width_bit: assert property (hardware_config_reg == {29'h0, bus_width_select, 2'h0})
    else $error("config word wrong");
  chk_width_held: assert property (up_q == 4'hF |-> $stable(bus_width_select))
    else $error("width moved");
  chk_upper_float: assert property (!bus_width_select |-> host_doe_n[31:16] == 16'hFFFF)
    else $error("upper lines driven");
  chk_wr_cause: assert property (core_wr |-> $past(host_wr) && core_addr[1:0] == 2'b00)
    else $error("commit without write");
  chk_rd_cause: assert property (core_rd |-> $past(host_rd) && !$past(host_wr))
    else $error("fetch without read");
  chk_rd_answer: assert property (core_rd |=> host_doe_n[15:0] == 16'h0)
    else $error("read data missing");
  chk_data_slot: assert property (host_doe_n[0] == 1'b0 |-> $past(host_rd, 2))
    else $error("data without read");
  chk_inv_lanes: assert property (host_rd_invalid |-> host_doe_n[15:0] == 16'h0)
    else $error("invalid flag outside slot");
  cover property (core_wr);
  cover property (core_rd);
  cover property (host_rd_invalid);
  cover property (core_rd && bus_width_select);
endmodule // hbwl_props

// *** sim/hbwl_host.sv ***
// host processor model: one-cycle strobes on the sram-like port
// assumes the caller spaces accesses as the adapter allows
`timescale 1ns/1ps
module hbwl_host (
  input wire clk,
  output reg host_wr = 1'b0,
  output reg host_rd = 1'b0,
  output reg [7:0] host_addr = 8'h00,
  output reg [31:0] host_din = 32'h0
);
  task acc(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      host_wr <= w;
      host_rd <= !w;
      host_addr <= a;
      host_din <= d;
      @(posedge clk);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      // released bus shows no stale value
      host_din <= ~d;
    end
  endtask
endmodule // hbwl_host

// *** sim/test_host_bus_width_lane_adapter.sv ***
// self-checking bench for the lane adapter, 16-bit first, 32-bit after a second reset
// assumes the core answers combinationally from core_addr
`timescale 1ns/1ps
module test_host_bus_width_lane_adapter;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg width_strap_pin = 1'b0;
  reg [31:0] byte_order = 32'h0;
  wire host_wr, host_rd, host_rd_invalid, core_wr, core_rd, bus_width_select;
  wire [7:0] host_addr, core_addr;
  wire [31:0] host_din, host_dout, host_doe_n, core_wdata, hardware_config_reg, core_rdata;
  reg [31:0] wd_q = 32'h0;
  reg [7:0] wa_q = 8'h00;
  reg [15:0] r = 16'h9;
  reg s, f;
  reg [7:0] a;
  integer bad_count = 0;
  integer n_tests = 0;
  integer k;
  always #5 clk = ~clk;
  function [31:0] mem(input [7:0] x);
    mem = {x, ~x, 8'h5A, x ^ 8'hC3};
  endfunction
  function [15:0] half(input [31:0] w, input hi);
    half = hi ? w[31:16] : w[15:0];
  endfunction
  // 16-bit lfsr step for repeatable stimulus
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  assign core_rdata = mem(core_addr);
  hbwl_host host (
    .clk(clk),
    .host_wr(host_wr),
    .host_rd(host_rd),
    .host_addr(host_addr),
    .host_din(host_din)
  );
  hbwl_adapter #(.AW(8)) uut (
    .clk(clk),
    .srst(srst),
    .width_strap_pin(width_strap_pin),
    .byte_order(byte_order),
    .host_wr(host_wr),
    .host_rd(host_rd),
    .host_addr(host_addr),
    .host_din(host_din),
    .host_dout(host_dout),
    .host_doe_n(host_doe_n),
    .host_rd_invalid(host_rd_invalid),
    .core_wr(core_wr),
    .core_rd(core_rd),
    .core_addr(core_addr),
    .core_wdata(core_wdata),
    .core_rdata(core_rdata),
    .hardware_config_reg(hardware_config_reg),
    .bus_width_select(bus_width_select)
  );
  // capture committed dwords and their address
  always @(posedge clk) begin
    if (core_wr === 1'b1) begin
      wd_q <= core_wdata;
      wa_q <= core_addr;
    end
  end
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rd(input hi, input inv);
    begin
      host.acc(1'b0, a | {hi ^ s, 1'b0}, 32'h0);
      @(posedge clk);
      #1;
      check("rdata", host_dout, {16'h0000, half(mem(a), hi ^ inv)});
      check("roe", host_doe_n, 32'hFFFF0000);
      check("rinv", host_rd_invalid, inv);
    end
  endtask
  task rd32;
    begin
      host.acc(1'b0, a, 32'h00000000);
      @(posedge clk);
      #1;
      check("rd32", host_dout, mem(a));
      check("oe32", host_doe_n, 32'h00000000);
      check("inv32", host_rd_invalid, 1'b0);
    end
  endtask
  task conclude;
    begin
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #20000;
    bad_count = bad_count + 1;
    conclude;
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("cfg16", hardware_config_reg, 32'h00000000);
    check("sel16", bus_width_select, 1'b0);
    for (k = 0; k < 8; k = k + 1) begin
      r = lfsr(r);
      s = k[0];
      a = {r[5:0], 2'b00};
      f = r[6];
      @(posedge clk);
      byte_order <= s ? 32'hFFFFFFFF : {16'h0000, r};
      host.acc(1'b1, a | {f, 1'b0}, {r, r});
      if (r[7] || k < 2) host.acc(1'b1, a | {f, 1'b0}, {r, r ^ 16'h0FF0});
      host.acc(1'b1, a | {!f, 1'b0}, {r, ~r});
      @(posedge clk);
      #1;
      check("wdata", wd_q, (f ^ s) ? {r, ~r} : {~r, r});
      check("waddr", wa_q, a);
      rd(f ^ s, 1'b0);
      rd(!(f ^ s), 1'b0);
      rd(f ^ s, 1'b0);
      rd(f ^ s, 1'b1);
      rd(!(f ^ s), 1'b0);
      rd(f ^ s, 1'b0);
      $display("test %0d done", k);
    end
    // mid-run reset with the strap high selects 32-bit mode
    @(posedge clk);
    srst <= 1'b1;
    width_strap_pin <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("cfg32", hardware_config_reg, 32'h00000004);
    check("sel32", bus_width_select, 1'b1);
    for (k = 0; k < 4; k = k + 1) begin
      r = lfsr(r);
      a = {r[5:0], 2'b00};
      @(posedge clk);
      byte_order <= k[0] ? 32'hFFFFFFFF : {16'h0000, r};
      host.acc(1'b1, a | {r[7], 1'b0}, {~r, r});
      @(posedge clk);
      #1;
      check("wdata32", wd_q, {~r, r});
      check("waddr32", wa_q, a);
      rd32;
      rd32;
      $display("test %0d done", k + 8);
    end
    conclude;
  end
endmodule // test_host_bus_width_lane_adapter
bind hbwl_adapter hbwl_props #(.AW(AW)) u_chk (
  .clk(clk),
  .srst(srst),
  .host_wr(host_wr),
  .host_rd(host_rd),
  .host_dout(host_dout),
  .host_doe_n(host_doe_n),
  .host_rd_invalid(host_rd_invalid),
  .core_wr(core_wr),
  .core_rd(core_rd),
  .core_addr(core_addr),
  .hardware_config_reg(hardware_config_reg),
  .bus_width_select(bus_width_select)
);
